// *** design/i2sw_base.sv ***
/*
 * Shared constants and types of the four-channel bus switch, and the
 * two-flop synchroniser used on every pin input.
 * Assumes one core clock and an asynchronous active-low reset.
 */
package i2sw_pkg;
    localparam int CHAN_N = 4;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    // Fixed upper five bits of the target address; the value is arbitrary.
    localparam logic [4:0] ADDR_FIXED_HI = 5'h0E;
    localparam logic [CHAN_N-1:0] CHAN_RESET = 4'h0;
    localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;
    localparam logic RW_READ = 1'b1;
    // Highest bus clock rate that the oversampling must keep up with.
    localparam int SCL_MAX_KHZ = 400;
    localparam int CORE_MHZ = 200;
    localparam int SCL_HALF_CYC = (CORE_MHZ * 1000) / (2 * SCL_MAX_KHZ);

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WR_DATA = 7'h08,
        ST_WR_ACK = 7'h10,
        ST_RD_DATA = 7'h20,
        ST_RD_ACK = 7'h40
    } i2sw_state_t;

    // Bus events decoded from the sampled upstream lines.
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } i2sw_bus_ev_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

module i2sw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_reg[i] <= 1'b1;
                    q[i] <= 1'b1;
                end else begin
                    meta_reg[i] <= d[i];
                    q[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule // i2sw_sync

`default_nettype wire

// *** design/i2sw_switch_ctrl.sv ***
/*
 * Target-side logic of a four-channel bus switch: serial target that
 * accepts one control byte, channel enables applied at stop, and the
 * combined active-low interrupt.
 * Assumes the upstream master keeps to the two-wire bus protocol and that
 * the open-drain pins are resolved outside (oe high pulls the line low).
 */
// How it works
// - Two address bits compared with strap inputs.
// - Direction bit one reads, zero writes.
// - First data byte after address stored in control.
// - Several bytes: only the last one kept.
// - Read returns control register in low nibble.
// - Bits zero to three enable channels zero-three.
// - Any combination of channels accepted.
// - New selection connects only after stop condition.
// - Interrupt output is AND of four inputs.
// - Bits four to seven show live interrupt inputs.
// - Interrupt detection ignores channel enable state.
// - Reset pin idles machine, deselects all channels.
// - Power-up leaves all channels deselected.
// - Any reset clears control register to zero.
// - Bus works from zero to 400 kHz.
`timescale 1ns/1ps
`default_nettype none

module i2sw_switch_ctrl
    import i2sw_pkg::*;
(
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Reset pin and address straps
    input wire logic reset_in_n,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    // Upstream bus
    input wire logic up_scl_in,
    input wire logic up_sda_in,
    output logic up_sda_out,
    output logic up_sda_oe,
    // Downstream channel enables
    output logic chan_en_0,
    output logic chan_en_1,
    output logic chan_en_2,
    output logic chan_en_3,
    // Interrupts
    input wire logic chan_irq_in_n_0,
    input wire logic chan_irq_in_n_1,
    input wire logic chan_irq_in_n_2,
    input wire logic chan_irq_in_n_3,
    output logic irq_out_n,
    output logic irq_out_oe
);
    logic [8:0] pin_raw;
    logic [8:0] pin_sync;
    logic scl_s, sda_s, rst_pin_n_s;
    logic [1:0] strap_s;
    logic [CHAN_N-1:0] irq_n_s;
    logic scl_d_reg, sda_d_reg;
    i2sw_bus_ev_t ev;
    i2sw_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [BYTE_W-1:0] shift_reg;
    logic [BYTE_W-1:0] tx_reg;
    logic [CHAN_N-1:0] ctrl_reg;
    logic [CHAN_N-1:0] chan_en_reg;
    logic pending_reg;
    logic nack_reg;
    logic sda_drive_reg;
    logic irq_out_n_reg;
    logic byte_done;
    logic addr_match;
    logic [BYTE_W-1:0] read_byte;

    // Every pin passes two flops; 200 MHz oversampling leaves at least
    // SCL_HALF_CYC samples per half period even at the fastest bus rate.
    assign pin_raw = {reset_in_n, addr_strap_bit1, addr_strap_bit0, up_scl_in, up_sda_in,
                      chan_irq_in_n_3, chan_irq_in_n_2, chan_irq_in_n_1, chan_irq_in_n_0};

    i2sw_sync #(.W(9)) u_sync (
        .clk(core_clk),
        .arst_n(arst_n),
        .d(pin_raw),
        .q(pin_sync)
    );

    assign {rst_pin_n_s, strap_s, scl_s, sda_s, irq_n_s} = pin_sync;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    always_comb begin
        ev.scl_rise = scl_s & ~scl_d_reg;
        ev.scl_fall = ~scl_s & scl_d_reg;
        ev.start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
        ev.stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
        ev.sda = sda_s;
    end

    assign byte_done = (cnt_reg == BITS_PER_BYTE);
    assign addr_match = (shift_reg[7:3] == ADDR_FIXED_HI) && (shift_reg[2:1] == strap_s);
    // Upper nibble is the live interrupt state, one meaning pending.
    assign read_byte = {~irq_n_s, ctrl_reg};

    // Bus state machine.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
        end else if (!rst_pin_n_s) begin
            state_reg <= ST_IDLE;
        end else if (ev.start) begin
            state_reg <= ST_ADDR;
        end else if (ev.stop) begin
            state_reg <= ST_IDLE;
        end else if (ev.scl_fall) begin
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done) begin
                        state_reg <= addr_match ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    state_reg <= (shift_reg[0] == RW_READ) ? ST_RD_DATA : ST_WR_DATA;
                end
                ST_WR_DATA: begin
                    if (byte_done) begin
                        state_reg <= ST_WR_ACK;
                    end
                end
                ST_WR_ACK: begin
                    state_reg <= ST_WR_DATA;
                end
                ST_RD_DATA: begin
                    if (byte_done) begin
                        state_reg <= ST_RD_ACK;
                    end
                end
                ST_RD_ACK: begin
                    state_reg <= nack_reg ? ST_IDLE : ST_RD_DATA;
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Bit counter, receive shifter and acknowledge sampling.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= CNT_ZERO;
            shift_reg <= CTRL_RESET;
            nack_reg <= 1'b0;
        end else if (!rst_pin_n_s || ev.start) begin
            cnt_reg <= CNT_ZERO;
        end else if (ev.scl_rise) begin
            // Acknowledge slots neither shift nor count, so the direction bit
            // survives until the address acknowledge ends and every byte
            // starts from a zero count.
            if (state_reg == ST_RD_ACK) begin
                nack_reg <= ev.sda;
            end else if (!byte_done && (state_reg == ST_ADDR || state_reg == ST_WR_DATA
                                        || state_reg == ST_RD_DATA)) begin
                shift_reg <= {shift_reg[6:0], ev.sda};
                cnt_reg <= cnt_reg + 4'h1;
            end
        end else if (ev.scl_fall && byte_done) begin
            cnt_reg <= CNT_ZERO;
        end
    end

    // Control register; a later byte in the same transfer overwrites.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= CHAN_RESET;
            pending_reg <= 1'b0;
        end else if (!rst_pin_n_s) begin
            ctrl_reg <= CHAN_RESET;
            pending_reg <= 1'b0;
        end else if (ev.scl_fall && state_reg == ST_WR_DATA && byte_done) begin
            ctrl_reg <= shift_reg[CHAN_N-1:0];
            pending_reg <= 1'b1;
        end else if (ev.stop) begin
            pending_reg <= 1'b0;
        end
    end

    // Channels switch only at stop, when every line is idle high, or clear while the reset pin is low.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_en_reg <= CHAN_RESET;
        end else if (!rst_pin_n_s) begin
            chan_en_reg <= CHAN_RESET;
        end else if (ev.stop && pending_reg) begin
            chan_en_reg <= ctrl_reg;
        end
    end

    // Transmit byte is captured when a read byte begins.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_reg <= CTRL_RESET;
        end else if (ev.scl_fall && state_reg == ST_RD_DATA && !byte_done) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end else if (ev.scl_fall && (state_reg == ST_ADDR_ACK
                                     || (state_reg == ST_RD_ACK && !nack_reg))) begin
            tx_reg <= read_byte;
        end
    end

    // Data line driver; it changes after a falling clock edge, and clears at start, at stop or while the reset pin is low.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_drive_reg <= 1'b0;
        end else if (!rst_pin_n_s || ev.start || ev.stop) begin
            sda_drive_reg <= 1'b0;
        end else if (ev.scl_fall) begin
            case (state_reg)
                ST_ADDR: begin
                    sda_drive_reg <= byte_done && addr_match;
                end
                ST_ADDR_ACK: begin
                    sda_drive_reg <= (shift_reg[0] == RW_READ) ? ~read_byte[7] : 1'b0;
                end
                ST_WR_DATA: begin
                    sda_drive_reg <= byte_done;
                end
                ST_RD_DATA: begin
                    sda_drive_reg <= byte_done ? 1'b0 : ~tx_reg[6];
                end
                ST_RD_ACK: begin
                    sda_drive_reg <= nack_reg ? 1'b0 : ~read_byte[7];
                end
                default: begin
                    sda_drive_reg <= 1'b0;
                end
            endcase
        end
    end

    // Interrupt output follows the inputs regardless of channel enables.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_out_n_reg <= 1'b1;
        end else begin
            irq_out_n_reg <= &irq_n_s;
        end
    end

    assign up_sda_out = 1'b0;
    assign up_sda_oe = sda_drive_reg;
    assign {chan_en_3, chan_en_2, chan_en_1, chan_en_0} = chan_en_reg;
    assign irq_out_n = 1'b0;
    assign irq_out_oe = ~irq_out_n_reg;

endmodule // i2sw_switch_ctrl

`default_nettype wire

// *** tb/i2sw_asserts.sv ***
/* Port-level assertions for the bus switch target, bound to its top module.
   Assumes two synchroniser flops on every pin input and one core clock. */
`timescale 1ns/1ps
`default_nettype none
module i2sw_asserts (
    // Clock and resets
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic reset_in_n,
    // Upstream bus
    input wire logic up_scl_in,
    input wire logic up_sda_in,
    input wire logic up_sda_out,
    input wire logic up_sda_oe,
    // Channels and interrupts
    input wire logic chan_en_0,
    input wire logic chan_en_1,
    input wire logic chan_en_2,
    input wire logic chan_en_3,
    input wire logic chan_irq_in_n_0,
    input wire logic chan_irq_in_n_1,
    input wire logic chan_irq_in_n_2,
    input wire logic chan_irq_in_n_3,
    input wire logic irq_out_n,
    input wire logic irq_out_oe
);
    wire logic [3:0] chan = {chan_en_3, chan_en_2, chan_en_1, chan_en_0};
    wire logic [3:0] irq_n = {chan_irq_in_n_3, chan_irq_in_n_2, chan_irq_in_n_1, chan_irq_in_n_0};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_irq_and; $stable(irq_n) [*5] |-> irq_out_oe == !(&irq_n); endproperty
    a_irq_and: assert property (p_irq_and)
        else $error("interrupt output does not follow inputs");
    property p_chan_rst; !reset_in_n [*4] |-> chan == 4'h0; endproperty
    a_chan_rst: assert property (p_chan_rst)
        else $error("channels kept through reset pin");
    property p_rst_oe; !reset_in_n [*4] |-> !up_sda_oe; endproperty
    a_rst_oe: assert property (p_rst_oe)
        else $error("data line held through reset pin");
    property p_chan_hold;
        !$stable(chan) |-> (up_scl_in && up_sda_in) || !$past(reset_in_n, 3);
    endproperty
    a_chan_hold: assert property (p_chan_hold)
        else $error("channels changed while bus busy");
    property p_oe_scl_low; !$stable(up_sda_oe) |-> !up_scl_in || !$past(reset_in_n, 3); endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data line changed while clock high");
    property p_oe_latency;
        !$stable(up_sda_oe) && reset_in_n |-> $past(up_scl_in, 3) || $past(up_scl_in, 4)
            || $past(up_scl_in, 5) || $past(up_scl_in, 6);
    endproperty
    a_oe_latency: assert property (p_oe_latency)
        else $error("data line changed too late after clock fall");
    property p_oe_stand; $rose(up_sda_oe) |=> up_sda_oe [*8]; endproperty
    a_oe_stand: assert property (p_oe_stand)
        else $error("data line pull too short");
    property p_od_levels; up_sda_out == 1'b0 && irq_out_n == 1'b0; endproperty
    a_od_levels: assert property (p_od_levels)
        else $error("open-drain level not low");
    c_ack: cover property ($rose(up_sda_oe));
    c_chan: cover property (!$stable(chan) && chan != 4'h0);
    c_irq: cover property ($rose(irq_out_oe));
endmodule // i2sw_asserts
bind i2sw_switch_ctrl i2sw_asserts i2sw_asserts_i (.*);
`default_nettype wire

// *** tb/i2sw_master.sv ***
/* Upstream bus master model with a 160 ns bus clock.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module i2sw_master (
    // Phase reference
    input wire logic core_clk,
    // Bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // The bus clock stands high between frames and a released line reads high.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One quarter of the bus clock is eight core cycles; lines move only
    // on a core edge, one quarter apart, so no signal is set twice at once.
    task automatic quarter();
        repeat (8) @(posedge core_clk);
    endtask
    task automatic start();
        @(posedge core_clk);
        sda_low <= 1'b0;
        scl <= 1'b1;
        quarter();
        sda_low <= 1'b1;
        quarter();
        scl <= 1'b0;
        quarter();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        quarter();
        scl <= 1'b1;
        quarter();
        sda_low <= 1'b0;
        quarter();
        quarter();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        quarter();
        scl <= 1'b1;
        quarter();
        r = sda;
        quarter();
        scl <= 1'b0;
        quarter();
    endtask
    task automatic xb(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
        output logic ack_out);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack_out);
    endtask
endmodule // i2sw_master
`default_nettype wire

// *** tb/tb.sv ***
/* Self-checking bench of the bus switch target.
   Assumes the design, checker and master model are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb
    import i2sw_pkg::*;
;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic reset_in_n = 1'b1;
    logic [1:0] strap = 2'h2;
    logic [3:0] irq_n = 4'hF;
    logic scl, m_low, sda_oe, irq_oe, ack;
    logic [7:0] rx;
    wire logic [3:0] chan;
    wire logic sda = !(m_low || sda_oe);
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    i2sw_switch_ctrl i2sw_switch_ctrl_i (.core_clk, .arst_n, .reset_in_n,
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .up_scl_in(scl),
        .up_sda_in(sda), .up_sda_out(), .up_sda_oe(sda_oe), .chan_en_0(chan[0]),
        .chan_en_1(chan[1]), .chan_en_2(chan[2]), .chan_en_3(chan[3]),
        .chan_irq_in_n_0(irq_n[0]), .chan_irq_in_n_1(irq_n[1]), .chan_irq_in_n_2(irq_n[2]),
        .chan_irq_in_n_3(irq_n[3]), .irq_out_n(), .irq_out_oe(irq_oe));
    i2sw_master i2sw_master_i (.core_clk, .scl, .sda_low(m_low), .sda);
    initial forever #2.5 core_clk = !core_clk;
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    function automatic logic [7:0] adr(input logic [1:0] s, input logic rw);
        return {ADDR_FIXED_HI, s, rw};
    endfunction
    task automatic rd(input logic [7:0] exp);
        i2sw_master_i.start();
        i2sw_master_i.xb(adr(strap, RW_READ), 1'b1, rx, ack);
        i2sw_master_i.xb(8'hFF, 1'b1, rx, ack);
        i2sw_master_i.stop();
        chk(rx, exp, "read value");
    endtask
    task automatic t_write();
        i2sw_master_i.start();
        i2sw_master_i.xb(adr(strap, !RW_READ), 1'b1, rx, ack);
        chk({7'h0, ack}, 8'h00, "address not acked");
        i2sw_master_i.xb(8'hF5, 1'b1, rx, ack);
        i2sw_master_i.xb(8'h3A, 1'b1, rx, ack);
        chk({7'h0, ack}, 8'h00, "data not acked");
        chk({4'h0, chan}, 8'h00, "channels switched before stop");
        i2sw_master_i.stop();
        chk({4'h0, chan}, 8'h0A, "channel enables");
        rd(8'h0A);
    endtask
    task automatic t_badaddr();
        for (int s = 0; s < 4; s++) begin
            if (s[1:0] != strap) begin
                i2sw_master_i.start();
                i2sw_master_i.xb(adr(s[1:0], 1'b0), 1'b1, rx, ack);
                chk({7'h0, ack}, 8'h01, "foreign address acked");
                i2sw_master_i.xb(8'h01, 1'b1, rx, ack);
                i2sw_master_i.stop();
            end
        end
        chk({4'h0, chan}, 8'h0A, "foreign write took effect");
    endtask
    task automatic t_irq();
        @(posedge core_clk) irq_n <= 4'hA;
        repeat (6) @(posedge core_clk);
        chk({7'h0, irq_oe}, 8'h01, "interrupt output idle");
        rd(8'h5A);
        @(posedge core_clk) irq_n <= 4'hF;
        repeat (6) @(posedge core_clk);
        chk({7'h0, irq_oe}, 8'h00, "interrupt output stuck");
    endtask
    task automatic t_rstpin();
        @(posedge core_clk) reset_in_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk({4'h0, chan}, 8'h00, "channels kept by reset pin");
        reset_in_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(8'h00);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk({4'h0, chan}, 8'h00, "channels after power-up");
        rd(8'h00);
        t_write();
        t_badaddr();
        t_irq();
        t_rstpin();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
